// File: core/tccu_top.v
`timescale 1ns/100ps
`include "tccu_map.vh"
module tccu_top (
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire ext_clk_i,
  input wire ch_in_i,
  output reg ch_out_o,
  output wire ch_out_en_o,
  output reg adc_trig_o,
  output wire irq_o
);
  reg [7:0] timer_control;
  reg [3:0] timer_clock_source_select;
  reg [7:0] channel_control;
  reg [15:0] sixteen_bit_counter;
  reg [15:0] ch_value;
  reg [15:0] pwm_period;
  reg adc_sel;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg gate_ff;
  reg [2:0] ps_cnt;
  reg [3:0] cap_cnt;
  reg [3:0] pulse_cnt;
  reg [7:0] hi_latch;
  reg [1:0] quarter_cnt;
  // two synchroniser flops per pin, then edge-detect stages; first stage read only by second
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  reg ext_s4;
  reg in_s1;
  reg in_s2;
  reg in_s3;
  wire [3:0] mode;
  wire timer_on;
  wire [1:0] ps_sel;
  wire int_clk;
  wire fosc_tick;
  wire tick_src;
  wire ps_done;
  wire tick;
  wire wrap;
  wire match;
  wire rise;
  wire fall;
  wire cap_ev;
  wire cmp_ev;
  wire clr_timer;
  wire ch_event;
  wire wr_lo;
  wire wr_hi;
  wire pwm_wrap;
  wire [1:0] irq_clr;
  reg [2:0] ps_limit;

  assign mode = channel_control[3:0];
  assign timer_on = timer_control[`TCCU_CTRL_ON];
  assign ps_sel = timer_control[`TCCU_CTRL_PS_HI:`TCCU_CTRL_PS_LO];
  assign int_clk = (timer_clock_source_select == `TCCU_CS_FOSC) ||
                   (timer_clock_source_select == `TCCU_CS_FOSC4);
  // fosc/4 is an enable every fourth clock, not a second clock domain
  assign fosc_tick = (timer_clock_source_select == `TCCU_CS_FOSC) | (quarter_cnt == 2'h3);
  // raw mode edge-detects right behind the two pin flops; the synchronised
  // path costs one more clock of latency
  assign tick_src = int_clk ? fosc_tick :
                    (timer_control[`TCCU_CTRL_SYNC] ? (ext_s3 & ~ext_s4) :
                     (ext_s2 & ~ext_s3));

  always @* begin
    case (ps_sel)
      2'b00: ps_limit = 3'h0;
      2'b01: ps_limit = 3'h1;
      2'b10: ps_limit = 3'h3;
      default: ps_limit = 3'h7;
    endcase
  end

  // free running, so the quarter-rate phase never depends on register writes
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      quarter_cnt <= 2'h0;
    else
      quarter_cnt <= quarter_cnt + 2'h1;
  end

  assign ps_done = (ps_cnt == ps_limit);
  assign tick = timer_on & gate_ff & tick_src & ps_done;
  assign wrap = tick & (sixteen_bit_counter == 16'hFFFF);
  assign match = (sixteen_bit_counter == ch_value);
  assign rise = in_s2 & ~in_s3;
  assign fall = ~in_s2 & in_s3;
  assign wr_lo = wr_i & (addr_i == `TCCU_OFS_CNT_LO);
  assign wr_hi = wr_i & (addr_i == `TCCU_OFS_CNT_HI);
  assign irq_clr = (wr_i && addr_i == `TCCU_OFS_IRQ_STAT) ? wdata_i[1:0] : 2'b00;

  reg cap_hit;
  always @* begin
    cap_hit = 1'b0;
    case (mode)
      `TCCU_M_CAP_ANY: cap_hit = rise | fall;
      `TCCU_M_CAP_FALL: cap_hit = fall;
      `TCCU_M_CAP_RISE: cap_hit = rise;
      `TCCU_M_CAP_4: cap_hit = rise & (cap_cnt[1:0] == 2'h3);
      `TCCU_M_CAP_16: cap_hit = rise & (cap_cnt == 4'hF);
      default: cap_hit = 1'b0;
    endcase
  end

  // compare, clear and capture class decode; codes left out of every case raise no events, but ch_out_en_o still goes high for all of them except TCCU_M_OFF
  reg is_cmp;
  reg is_cmp_clr;
  reg is_cap;
  always @* begin
    is_cmp = 1'b0;
    is_cmp_clr = 1'b0;
    is_cap = 1'b0;
    case (mode)
      `TCCU_M_TGLCLR: begin
        is_cmp = 1'b1;
        is_cmp_clr = 1'b1;
      end
      `TCCU_M_TGL: is_cmp = 1'b1;
      `TCCU_M_SET: is_cmp = 1'b1;
      `TCCU_M_CLR: is_cmp = 1'b1;
      `TCCU_M_PULSE: is_cmp = 1'b1;
      `TCCU_M_PULSECLR: begin
        is_cmp = 1'b1;
        is_cmp_clr = 1'b1;
      end
      `TCCU_M_PWM: is_cmp = 1'b1;
      `TCCU_M_CAP_ANY: is_cap = 1'b1;
      `TCCU_M_CAP_FALL: is_cap = 1'b1;
      `TCCU_M_CAP_RISE: is_cap = 1'b1;
      `TCCU_M_CAP_4: is_cap = 1'b1;
      `TCCU_M_CAP_16: is_cap = 1'b1;
      default: is_cmp = 1'b0;
    endcase
  end

  // compare fires once per timer value, in the clock after the tick that lands on it
  reg cmp_arm;
  assign cap_ev = channel_control[`TCCU_CH_EN] & cap_hit;
  assign cmp_ev = channel_control[`TCCU_CH_EN] & match & cmp_arm & is_cmp;
  // pwm restarts the timer at the period register, so the compare value
  // is free to act as the duty threshold
  assign pwm_wrap = channel_control[`TCCU_CH_EN] & (mode == `TCCU_M_PWM) & tick &
                    (sixteen_bit_counter == pwm_period);
  assign clr_timer = (cmp_ev & is_cmp_clr) | pwm_wrap;
  assign ch_event = cap_ev | cmp_ev;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_s4 <= 1'b0;
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_s4 <= ext_s3;
      in_s1 <= ch_in_i;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // timer, prescaler, gate flop
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sixteen_bit_counter <= 16'h0000;
      ps_cnt <= 3'h0;
      gate_ff <= 1'b0;
      cmp_arm <= 1'b1;
    end else begin
      if (!timer_on) begin
        gate_ff <= 1'b0;
        ps_cnt <= 3'h0;
      end else begin
        gate_ff <= 1'b1;
        if (tick_src)
          ps_cnt <= ps_done ? 3'h0 : ps_cnt + 3'h1;
      end
      if (wr_lo)
        sixteen_bit_counter <= {hi_latch, wdata_i};
      else if (clr_timer)
        sixteen_bit_counter <= 16'h0000;
      else if (tick)
        sixteen_bit_counter <= sixteen_bit_counter + 16'h0001;
      cmp_arm <= tick | wr_lo | clr_timer ? 1'b1 : (cmp_ev ? 1'b0 : cmp_arm);
    end
  end

  // channel output and capture
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ch_out_o <= 1'b0;
      cap_cnt <= 4'h0;
      pulse_cnt <= 4'h0;
      adc_trig_o <= 1'b0;
    end else begin
      adc_trig_o <= ch_event & adc_sel;
      if (mode == `TCCU_M_OFF || !channel_control[`TCCU_CH_EN]) begin
        ch_out_o <= 1'b0;
        cap_cnt <= 4'h0;
        pulse_cnt <= 4'h0;
      end else begin
        if (rise)
          cap_cnt <= cap_cnt + 4'h1;
        if (pulse_cnt != 4'h0) begin
          pulse_cnt <= pulse_cnt - 4'h1;
          if (pulse_cnt == 4'h1)
            ch_out_o <= 1'b0;
        end
        if (mode == `TCCU_M_PWM) begin
          // duty when counter below compare, period wraps via clear
          ch_out_o <= (sixteen_bit_counter < ch_value);
        end else if (cmp_ev) begin
          case (mode)
            `TCCU_M_TGLCLR, `TCCU_M_TGL: ch_out_o <= ~ch_out_o;
            `TCCU_M_SET: ch_out_o <= 1'b1;
            `TCCU_M_CLR: ch_out_o <= 1'b0;
            `TCCU_M_PULSE, `TCCU_M_PULSECLR: begin
              ch_out_o <= 1'b1;
              pulse_cnt <= `TCCU_PULSE_CYC;
            end
            default: ch_out_o <= ch_out_o;
          endcase
        end
      end
    end
  end

  // registers
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer_control <= `TCCU_RST_CTRL;
      timer_clock_source_select <= `TCCU_CS_FOSC4;
      channel_control <= `TCCU_RST_CH_CTRL;
      ch_value <= 16'h0000;
      pwm_period <= `TCCU_RST_PWM_PER;
      adc_sel <= 1'b0;
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
      hi_latch <= 8'h00;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `TCCU_OFS_CTRL: timer_control <= wdata_i & 8'h37;
          `TCCU_OFS_CNT_HI: hi_latch <= wdata_i;
          `TCCU_OFS_CLKSEL: timer_clock_source_select <= wdata_i[3:0];
          `TCCU_OFS_CH_CTRL: channel_control <= {wdata_i[7], 2'b00, wdata_i[4], wdata_i[3:0]};
          `TCCU_OFS_CH_LO: ch_value[7:0] <= wdata_i;
          `TCCU_OFS_CH_HI: ch_value[15:8] <= wdata_i;
          `TCCU_OFS_ADC_SEL: adc_sel <= wdata_i[0];
          `TCCU_OFS_IRQ_MASK: irq_mask <= wdata_i[1:0];
          `TCCU_OFS_PWM_PER_LO: pwm_period[7:0] <= wdata_i;
          `TCCU_OFS_PWM_PER_HI: pwm_period[15:8] <= wdata_i;
          default: hi_latch <= hi_latch;
        endcase
      end
      if (rd_i && addr_i == `TCCU_OFS_CNT_LO)
        hi_latch <= sixteen_bit_counter[15:8];
      if (mode == `TCCU_M_OFF)
        ch_value <= wr_i && addr_i == `TCCU_OFS_CH_LO ? {ch_value[15:8], wdata_i} :
                    wr_i && addr_i == `TCCU_OFS_CH_HI ? {wdata_i, ch_value[7:0]} :
                    ch_value;
      else if (cap_ev)
        ch_value <= sixteen_bit_counter;
      // set wins over a write-one clear
      irq_stat <= (irq_stat & ~irq_clr) | {ch_event, wrap};
    end
  end

  assign irq_o = |(irq_stat & irq_mask);
  assign ch_out_en_o = channel_control[`TCCU_CH_EN] & (mode != `TCCU_M_OFF) & ~is_cap;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        `TCCU_OFS_CTRL: rdata_o <= timer_control;
        `TCCU_OFS_CNT_LO: rdata_o <= sixteen_bit_counter[7:0];
        `TCCU_OFS_CNT_HI: rdata_o <= timer_control[`TCCU_CTRL_WIDE] ? hi_latch :
                                      sixteen_bit_counter[15:8];
        `TCCU_OFS_CLKSEL: rdata_o <= {4'h0, timer_clock_source_select};
        `TCCU_OFS_CH_CTRL: rdata_o <= {channel_control[7], 1'b0, ch_out_o,
                                       channel_control[4:0]};
        `TCCU_OFS_CH_LO: rdata_o <= ch_value[7:0];
        `TCCU_OFS_CH_HI: rdata_o <= ch_value[15:8];
        `TCCU_OFS_ADC_SEL: rdata_o <= {7'h00, adc_sel};
        `TCCU_OFS_IRQ_STAT: rdata_o <= {6'h00, irq_stat};
        `TCCU_OFS_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
        `TCCU_OFS_PWM_PER_LO: rdata_o <= pwm_period[7:0];
        `TCCU_OFS_PWM_PER_HI: rdata_o <= pwm_period[15:8];
        default: rdata_o <= 8'h00;
      endcase
    end else
      rdata_o <= 8'h00;
  end
endmodule // tccu_top

// File: core/tccu_map.vh
`ifndef TCCU_MAP_VH
`define TCCU_MAP_VH
// register offsets on the plain port (8-bit address)
`define TCCU_OFS_CTRL 8'h00
`define TCCU_OFS_CNT_LO 8'h01
`define TCCU_OFS_CNT_HI 8'h02
`define TCCU_OFS_CLKSEL 8'h03
`define TCCU_OFS_CH_CTRL 8'h04
`define TCCU_OFS_CH_LO 8'h05
`define TCCU_OFS_CH_HI 8'h06
`define TCCU_OFS_ADC_SEL 8'h07
`define TCCU_OFS_IRQ_STAT 8'h08
`define TCCU_OFS_IRQ_MASK 8'h09
`define TCCU_OFS_PWM_PER_LO 8'h0A
`define TCCU_OFS_PWM_PER_HI 8'h0B
// timer control fields
`define TCCU_CTRL_ON 0
`define TCCU_CTRL_WIDE 1
`define TCCU_CTRL_SYNC 2
`define TCCU_CTRL_PS_LO 4
`define TCCU_CTRL_PS_HI 5
// clock source codes
`define TCCU_CS_FOSC4 4'h0
`define TCCU_CS_FOSC 4'h1
`define TCCU_CS_EXT 4'h2
// channel control fields
`define TCCU_CH_EN 7
`define TCCU_CH_OUT 5
// channel modes
`define TCCU_M_OFF 4'h0
`define TCCU_M_TGLCLR 4'h1
`define TCCU_M_TGL 4'h2
`define TCCU_M_CAP_ANY 4'h3
`define TCCU_M_CAP_FALL 4'h4
`define TCCU_M_CAP_RISE 4'h5
`define TCCU_M_CAP_4 4'h6
`define TCCU_M_CAP_16 4'h7
`define TCCU_M_SET 4'h8
`define TCCU_M_CLR 4'h9
`define TCCU_M_PULSE 4'hA
`define TCCU_M_PULSECLR 4'hB
`define TCCU_M_PWM 4'hF
// interrupt status bits
`define TCCU_IRQ_OVF 0
`define TCCU_IRQ_CH 1
// reset values
`define TCCU_RST_CTRL 8'h00
`define TCCU_RST_CH_CTRL 8'h00
`define TCCU_RST_PWM_PER 16'hFFFF
// compare pulse width in system clocks
`define TCCU_PULSE_CYC 4'h1
`endif

// File: tb/tccu_pin_model.sv
`timescale 1ns/100ps
module tccu_pin_model (
  input wire clock_i,
  output logic ch_in_i,
  output logic ext_clk_i
);
  initial begin
    ch_in_i = 1'b0;
    ext_clk_i = 1'b0;
  end
  // each level held 4 clocks so the two-flop samplers never miss it
  task automatic edge_in(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock_i);
      ch_in_i <= ~ch_in_i;
    end
  endtask
  // ends low, so the pin is idle between bursts
  task automatic ext_ticks(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge clock_i);
      ext_clk_i <= ~ext_clk_i;
    end
  endtask
endmodule // tccu_pin_model

// File: tb/tccu_asserts.sv
`timescale 1ns/100ps
`include "tccu_map.vh"
module tccu_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire ch_out_o,
  input wire ch_out_en_o,
  input wire adc_trig_o,
  input wire irq_o
);
  logic [3:0] mode;
  logic ch_en;
  logic adc_sel;
  logic [1:0] mask;
  wire chan_on = ch_en && mode != 4'h0;
  wire is_cap = mode >= 4'h3 && mode <= 4'h7;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= 4'h0;
      ch_en <= 1'b0;
      adc_sel <= 1'b0;
      mask <= 2'h0;
    end else if (wr_i) begin
      if (addr_i == `TCCU_OFS_CH_CTRL) begin
        mode <= wdata_i[3:0];
        ch_en <= wdata_i[7];
      end
      if (addr_i == `TCCU_OFS_ADC_SEL) adc_sel <= wdata_i[0];
      if (addr_i == `TCCU_OFS_IRQ_MASK) mask <= wdata_i[1:0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence pulse_up;
    !ch_out_o ##1 ch_out_o;
  endsequence
  ctrl_layout_a: assert property (
    rd_i && addr_i == `TCCU_OFS_CTRL |=> rdata_o[7:6] == 2'h0 && !rdata_o[3])
    else $error("control reserved bits not zero");
  out_enable_a: assert property (ch_out_en_o == (chan_on && !is_cap))
    else $error("output enable wrong for mode");
  off_low_a: assert property (!chan_on |=> !ch_out_o)
    else $error("channel off but output high");
  pulse_width_a: assert property (
    pulse_up ##0 (chan_on && mode[3:1] == 3'h5) |=> !ch_out_o)
    else $error("compare pulse longer than one clock");
  set_hold_a: assert property (chan_on && mode == 4'h8 && ch_out_o |=> ch_out_o)
    else $error("set mode output fell");
  clr_hold_a: assert property (chan_on && mode == 4'h9 && !ch_out_o |=> !ch_out_o)
    else $error("clear mode output rose");
  adc_pulse_a: assert property (adc_trig_o |-> adc_sel ##1 !adc_trig_o)
    else $error("conversion trigger wrong");
  irq_mask_a: assert property (mask == 2'h0 |-> !irq_o)
    else $error("interrupt while all masked");
endmodule // tccu_asserts
bind tccu_top tccu_asserts chk_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ch_out_o(ch_out_o),
  .ch_out_en_o(ch_out_en_o), .adc_trig_o(adc_trig_o), .irq_o(irq_o));

// File: tb/tccu_bench.sv
`timescale 1ns/100ps
`include "tccu_map.vh"
module tccu_bench;
  logic clock_i, rst_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, a, b;
  wire [7:0] rdata_o;
  wire ch_in_i, ext_clk_i, ch_out_o, ch_out_en_o, adc_trig_o, irq_o;
  int errors, comparisons, adc_seen, i, m;
  logic [3:0] modes [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h2, 4'h1};
  logic [5:0] outs = 6'h1D;
  logic [5:0] clr = 6'h28;
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  tccu_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i), .ch_in_i(ch_in_i),
    .ch_out_o(ch_out_o), .ch_out_en_o(ch_out_en_o), .adc_trig_o(adc_trig_o), .irq_o(irq_o));
  tccu_pin_model pin_u (.clock_i(clock_i), .ch_in_i(ch_in_i), .ext_clk_i(ext_clk_i));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (adc_trig_o === 1'b1) adc_seen++;
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    `CHK("register", e, d)
  endtask
  // two count reads 64 clocks apart, so any fixed read latency cancels
  task automatic span(input logic [7:0] e);
    rd(`TCCU_OFS_CNT_LO, a);
    repeat (62) @(posedge clock_i);
    rd(`TCCU_OFS_CNT_LO, b);
    `CHK("count step", e, b - a)
  endtask
  task automatic cmp_step(input logic [3:0] md, input logic e);
    wr(`TCCU_OFS_CH_CTRL, {4'h8, md});
    wr(`TCCU_OFS_CNT_HI, 8'h00);
    wr(`TCCU_OFS_CNT_LO, 8'h00);
    m = 0;
    #1;
    while (ch_out_o !== e && m < 200) begin
      @(posedge clock_i);
      #1;
      m++;
    end
    `CHK("compare out", e, ch_out_o)
    if (m == 200) complete_run();
  endtask
  initial begin
    repeat (50000) @(posedge clock_i);
    errors++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(`TCCU_OFS_CTRL, `TCCU_RST_CTRL);
    rdc(`TCCU_OFS_CH_CTRL, `TCCU_RST_CH_CTRL);
    rdc(8'hFF, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(`TCCU_OFS_CTRL, {2'h0, 2'(i), 4'h1});
      span(8'(16 >> i));
    end
    wr(`TCCU_OFS_CTRL, 8'h00);
    span(8'h00);
    wr(`TCCU_OFS_CLKSEL, 8'h02);
    for (i = 0; i < 2; i++) begin
      wr(`TCCU_OFS_CTRL, i == 0 ? 8'h05 : 8'h01);
      rd(`TCCU_OFS_CNT_LO, a);
      pin_u.ext_ticks(5);
      repeat (6) @(posedge clock_i);
      rd(`TCCU_OFS_CNT_LO, b);
      `CHK("external count", 8'h05, b - a)
    end
    wr(`TCCU_OFS_CLKSEL, 8'h01);
    wr(`TCCU_OFS_CTRL, 8'h05);
    span(8'h40);
    wr(`TCCU_OFS_CTRL, 8'h00);
    wr(`TCCU_OFS_CLKSEL, 8'h01);
    wr(`TCCU_OFS_CNT_HI, 8'hFF);
    wr(`TCCU_OFS_CNT_LO, 8'hF0);
    wr(`TCCU_OFS_IRQ_STAT, 8'h03);
    wr(`TCCU_OFS_CTRL, 8'h01);
    repeat (30) @(posedge clock_i);
    rdc(`TCCU_OFS_IRQ_STAT, 8'h01);
    `CHK("irq masked", 1'b0, irq_o)
    wr(`TCCU_OFS_IRQ_MASK, 8'h01);
    @(negedge clock_i);
    `CHK("irq", 1'b1, irq_o)
    wr(`TCCU_OFS_IRQ_STAT, 8'h01);
    rdc(`TCCU_OFS_IRQ_STAT, 8'h00);
    wr(`TCCU_OFS_CH_HI, 8'h00);
    wr(`TCCU_OFS_CH_LO, 8'h20);
    for (i = 0; i < 6; i++) begin
      cmp_step(modes[i], outs[i]);
      repeat (100) @(posedge clock_i);
      rd(`TCCU_OFS_CNT_LO, a);
      `CHK("timer clear", clr[i], a <= 8'h21)
    end
    rdc(`TCCU_OFS_IRQ_STAT, 8'h02);
    wr(`TCCU_OFS_ADC_SEL, 8'h01);
    for (i = 3; i < 6; i++) begin
      wr(`TCCU_OFS_CH_CTRL, {4'h8, 4'(i)});
      wr(`TCCU_OFS_IRQ_STAT, 8'h03);
      pin_u.edge_in(1);
      repeat (8) @(posedge clock_i);
      rdc(`TCCU_OFS_IRQ_STAT, {6'h00, i != 4, 1'b0});
      wr(`TCCU_OFS_IRQ_STAT, 8'h03);
      pin_u.edge_in(1);
      repeat (8) @(posedge clock_i);
      rdc(`TCCU_OFS_IRQ_STAT, {6'h00, i != 5, 1'b0});
    end
    for (i = 4; i <= 16; i += 12) begin
      wr(`TCCU_OFS_CH_CTRL, 8'h00);
      wr(`TCCU_OFS_CH_CTRL, i == 4 ? 8'h86 : 8'h87);
      wr(`TCCU_OFS_IRQ_STAT, 8'h03);
      pin_u.edge_in(2 * i - 2);
      repeat (8) @(posedge clock_i);
      rdc(`TCCU_OFS_IRQ_STAT, 8'h00);
      pin_u.edge_in(2);
      repeat (8) @(posedge clock_i);
      rdc(`TCCU_OFS_IRQ_STAT, 8'h02);
    end
    `CHK("adc trigger", 1'b1, adc_seen > 0)
    wr(`TCCU_OFS_CH_CTRL, 8'h8C);
    wr(`TCCU_OFS_IRQ_STAT, 8'h03);
    cmp_step(4'hC, 1'b0);
    repeat (80) @(posedge clock_i);
    rdc(`TCCU_OFS_IRQ_STAT, 8'h00);
    wr(`TCCU_OFS_PWM_PER_LO, 8'h0F);
    wr(`TCCU_OFS_PWM_PER_HI, 8'h00);
    wr(`TCCU_OFS_CH_LO, 8'h04);
    wr(`TCCU_OFS_CH_HI, 8'h00);
    wr(`TCCU_OFS_CH_CTRL, 8'h8F);
    @(negedge clock_i);
    `CHK("pwm enable", 1'b1, ch_out_en_o)
    wr(`TCCU_OFS_CNT_HI, 8'h00);
    wr(`TCCU_OFS_CNT_LO, 8'h00);
    repeat (4) @(posedge clock_i);
    m = 0;
    repeat (32) begin
      @(posedge clock_i);
      #1 if (ch_out_o === 1'b1) m++;
    end
    `CHK("pwm duty", 8, m)
    wr(`TCCU_OFS_CH_CTRL, 8'h00);
    @(negedge clock_i);
    `CHK("off enable", 1'b0, ch_out_en_o)
    complete_run();
  end
endmodule // tccu_bench
